/* File: logic/twsw_pkg.sv */
// Package with constants, register map and types for the two-way winding switch
package twsw_pkg;
    localparam logic [3:0] ADDR_OP_SRC    = 4'h0;
    localparam logic [3:0] ADDR_SPD_SRC   = 4'h1;
    localparam logic [3:0] ADDR_SETTINGS  = 4'h2;
    localparam logic [3:0] ADDR_STATUS    = 4'h3;
    localparam logic [3:0] ADDR_NET_CMD   = 4'h4;
    localparam logic [3:0] ADDR_NET_SPEED = 4'h5;
    localparam logic [3:0] ADDR_ID        = 4'h6;
    localparam logic [0:0] OP_SRC_RST     = 1'h0;
    localparam logic [1:0] SPD_SRC_RST    = 2'h0;
    localparam logic [0:0] OP_SRC_NET     = 1'h0;
    localparam logic [1:0] SPD_SRC_NET    = 2'h0;
    localparam logic [1:0] SPD_SRC_EXT1   = 2'h1;
    localparam logic [1:0] SPD_SRC_EXT2   = 2'h2;
    localparam logic [1:0] SPD_SRC_MAX    = 2'h2;
    localparam logic [7:0] FUNC_TWO_WAY   = 8'h7E;
    localparam logic [7:0] FUNC_GAIN_TUNE = 8'h51;
    localparam int         SET_PID_BIT    = 0;
    localparam int         SET_WIND_BIT   = 1;
    localparam int         NC_TWO_WAY_BIT = 0;
    localparam int         NC_TUNE_BIT    = 1;
    localparam int         NC_FWD_BIT     = 2;
    localparam int         NC_REV_BIT     = 3;
    localparam int         NC_LOW_BIT     = 4;
    localparam int         NC_MID_BIT     = 5;
    localparam int         NC_HIGH_BIT    = 6;
    localparam int         NC_REX_BIT     = 7;
    localparam int         NC_WIDTH       = 8;
    localparam int         SPEED_W        = 16;
    localparam logic [15:0] BLOCK_ID      = 16'h5A3C;
    localparam logic [15:0] SPEED_ZERO    = 16'h0000;
    typedef enum logic [1:0] {
        TWSW_SPD_DANCER   = 2'b00,
        TWSW_SPD_TENSION  = 2'b01,
        TWSW_TRQ_SENSLESS = 2'b10,
        TWSW_TRQ_SENSOR   = 2'b11
    } twsw_mode_t;
    typedef enum logic [1:0] {
        TWSW_ST_NORMAL = 2'b00,
        TWSW_ST_HOLD   = 2'b01,
        TWSW_ST_SWAP   = 2'b10
    } twsw_state_t;
endpackage

/* File: logic/twsw_src_if.sv */
// Interface carrying selected command sources between source mux and core
`timescale 1ns/10ps
interface twsw_src_if;
    logic       two_way_req;
    logic       tune_cmd;
    logic       fwd_start;
    logic       rev_start;
    logic [2:0] step_speed;
    logic       rex_sel;
    logic       net_speed_ok;
    modport mux  (output two_way_req, tune_cmd, fwd_start, rev_start, step_speed,
                  rex_sel, net_speed_ok);
    modport core (input two_way_req, tune_cmd, fwd_start, rev_start, step_speed,
                  rex_sel, net_speed_ok);
endinterface

/* File: logic/twsw_src_mux.sv */
// Command source selection between network and external terminals
`timescale 1ns/10ps
module twsw_src_mux (
    input  wire logic                        i_op_src,
    input  wire logic [1:0]                  i_spd_src,
    input  wire logic [twsw_pkg::NC_WIDTH-1:0] i_net_cmd,
    input  wire logic                        i_term_two_way,
    input  wire logic                        i_term_tune,
    input  wire logic                        i_term_fwd,
    input  wire logic                        i_term_rev,
    input  wire logic [2:0]                  i_term_step,
    input  wire logic                        i_term_rex,
    twsw_src_if.mux                          src
);
    wire op_net  = (i_op_src == twsw_pkg::OP_SRC_NET);
    wire spd_ext = (i_spd_src == twsw_pkg::SPD_SRC_EXT1);
    wire [2:0] net_step = {i_net_cmd[twsw_pkg::NC_HIGH_BIT], i_net_cmd[twsw_pkg::NC_MID_BIT],
                           i_net_cmd[twsw_pkg::NC_LOW_BIT]};

    assign src.two_way_req  = op_net ? i_net_cmd[twsw_pkg::NC_TWO_WAY_BIT]
                                     : i_term_two_way;
    assign src.tune_cmd     = op_net ? i_net_cmd[twsw_pkg::NC_TUNE_BIT] : i_term_tune;
    assign src.fwd_start    = op_net ? i_net_cmd[twsw_pkg::NC_FWD_BIT] : i_term_fwd;
    assign src.rev_start    = op_net ? i_net_cmd[twsw_pkg::NC_REV_BIT] : i_term_rev;
    // Step speeds follow the speed source: external only for source 1
    assign src.step_speed   = spd_ext ? i_term_step : net_step;
    assign src.rex_sel      = spd_ext ? i_term_rex : i_net_cmd[twsw_pkg::NC_REX_BIT];
    assign src.net_speed_ok = !spd_ext;
endmodule

/* File: logic/twsw_ramp_zero.sv */
// Detects the ramped line speed settled at zero
`timescale 1ns/10ps
module twsw_ramp_zero (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_rstn,
    input  wire logic [twsw_pkg::SPEED_W-1:0] i_ramp_speed,
    input  wire logic                        i_ramp_busy,
    output logic                             o_at_zero
);
    logic at_zero_q;
    wire  at_zero_d = (i_ramp_speed == twsw_pkg::SPEED_ZERO) && !i_ramp_busy;

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            at_zero_q <= 1'b0;
        end else begin
            at_zero_q <= at_zero_d;
        end
    end
    assign o_at_zero = at_zero_q;
endmodule

/* File: logic/twsw_top.sv */
// Two-way winding switch with command source selection and register port
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
// Function
// - Two-way level selects swapped winding behaviour
// - Speed modes invert PID, winding, direction
// - Torque modes invert only winding selection
// - Works in all four control modes
// - No step in PID output at changeover
// - No further writes needed after changeover
// - Panel shows originally commanded start direction
// - Speed modes switch only at zero ramp
// - Network mode picks per command source
// - Operation source 0 network, 1 terminal
// - Speed source 0 net, 1/2 external; the code takes only 1 as external and handles 2 like net
// - Network line speed ignored for source 1
// - Gain tuning command follows operation source
// - Two-way command follows operation source
module twsw_top (
    input  wire logic                         i_core_clk,
    input  wire logic                         i_rstn,
    input  wire logic [3:0]                   i_reg_addr,
    input  wire logic [31:0]                  i_reg_wdata,
    input  wire logic                         i_reg_wr,
    input  wire logic                         i_reg_rd,
    output logic      [31:0]                  o_reg_rdata,
    input  wire logic [1:0]                   i_ctrl_mode,
    input  wire logic [7:0]                   i_term_func_sel,
    input  wire logic                         i_term_func_in,
    input  wire logic                         i_term_tune,
    input  wire logic                         i_forward_start_input,
    input  wire logic                         i_reverse_start_input,
    input  wire logic [2:0]                   i_term_step,
    input  wire logic                         i_term_rex,
    input  wire logic [twsw_pkg::SPEED_W-1:0] i_net_line_speed,
    input  wire logic [twsw_pkg::SPEED_W-1:0] i_ramp_speed,
    input  wire logic                         i_ramp_busy,
    input  wire logic [twsw_pkg::SPEED_W-1:0] i_pid_mv,
    output logic                              o_pid_sense,
    output logic                              o_wind_sel,
    output logic                              o_run_fwd,
    output logic                              o_run_rev,
    output logic                              o_panel_fwd,
    output logic                              o_panel_rev,
    output logic                              o_swapped,
    output logic      [twsw_pkg::SPEED_W-1:0] o_pid_mv,
    output logic      [twsw_pkg::SPEED_W-1:0] o_line_speed_cmd,
    output logic                              o_tune_cmd,
    output logic      [2:0]                   o_step_speed,
    output logic                              o_rex_sel
);
    logic                        op_src_q;
    logic [1:0]                  spd_src_q;
    logic [1:0]                  settings_q;
    logic [twsw_pkg::NC_WIDTH-1:0] net_cmd_q;
    logic [twsw_pkg::SPEED_W-1:0] net_speed_q;
    logic [31:0]                 rdata_q;
    logic                        req_s1_q;
    logic                        req_s2_q;
    logic                        swap_q;
    twsw_pkg::twsw_state_t       state_q;
    twsw_pkg::twsw_state_t       state_d;
    logic                        pid_sense_q;
    logic                        wind_sel_q;
    logic                        run_fwd_q;
    logic                        run_rev_q;
    logic                        panel_fwd_q;
    logic                        panel_rev_q;
    logic [twsw_pkg::SPEED_W-1:0] pid_mv_q;
    logic [twsw_pkg::SPEED_W-1:0] line_speed_q;
    logic                        tune_q;
    logic [2:0]                  step_q;
    logic                        rex_q;
    logic                        at_zero;

    twsw_src_if src ();

    // The assigned terminal only carries the two-way function when coded for it
    wire term_two_way = (i_term_func_sel == twsw_pkg::FUNC_TWO_WAY) && i_term_func_in;

    twsw_src_mux u_mux (
        .i_op_src       (op_src_q),
        .i_spd_src      (spd_src_q),
        .i_net_cmd      (net_cmd_q),
        .i_term_two_way (term_two_way),
        .i_term_tune    (i_term_tune),
        .i_term_fwd     (i_forward_start_input),
        .i_term_rev     (i_reverse_start_input),
        .i_term_step    (i_term_step),
        .i_term_rex     (i_term_rex),
        .src            (src)
    );

    twsw_ramp_zero u_zero (
        .i_core_clk   (i_core_clk),
        .i_rstn       (i_rstn),
        .i_ramp_speed (i_ramp_speed),
        .i_ramp_busy  (i_ramp_busy),
        .o_at_zero    (at_zero)
    );

    // Register decode
    wire wr_op    = i_reg_wr && (i_reg_addr == twsw_pkg::ADDR_OP_SRC);
    wire wr_spd   = i_reg_wr && (i_reg_addr == twsw_pkg::ADDR_SPD_SRC);
    wire wr_set   = i_reg_wr && (i_reg_addr == twsw_pkg::ADDR_SETTINGS);
    wire wr_cmd   = i_reg_wr && (i_reg_addr == twsw_pkg::ADDR_NET_CMD);
    wire wr_speed = i_reg_wr && (i_reg_addr == twsw_pkg::ADDR_NET_SPEED);
    // Out-of-range speed source values are dropped so the selector stays legal
    wire spd_ok   = (i_reg_wdata[1:0] <= twsw_pkg::SPD_SRC_MAX);
    wire [31:0] status_word = {24'h000000, 3'h0, at_zero, state_q, 1'b0, swap_q};

    // One-hot address match; an unmapped index matches nothing and reads as zero
    wire sel_op     = (i_reg_addr == twsw_pkg::ADDR_OP_SRC);
    wire sel_spd    = (i_reg_addr == twsw_pkg::ADDR_SPD_SRC);
    wire sel_set    = (i_reg_addr == twsw_pkg::ADDR_SETTINGS);
    wire sel_status = (i_reg_addr == twsw_pkg::ADDR_STATUS);
    wire sel_cmd    = (i_reg_addr == twsw_pkg::ADDR_NET_CMD);
    wire sel_speed  = (i_reg_addr == twsw_pkg::ADDR_NET_SPEED);
    wire sel_id     = (i_reg_addr == twsw_pkg::ADDR_ID);

    wire [31:0] rd_op    = {31'h0, op_src_q};
    wire [31:0] rd_spd   = {30'h0, spd_src_q};
    wire [31:0] rd_set   = {30'h0, settings_q};
    wire [31:0] rd_cmd   = {24'h0, net_cmd_q};
    wire [31:0] rd_speed = {16'h0, net_speed_q};
    wire [31:0] rd_id    = {16'h0, twsw_pkg::BLOCK_ID};

    wire [31:0] rdata_d  = ({32{sel_op}} & rd_op) | ({32{sel_spd}} & rd_spd) |
                           ({32{sel_set}} & rd_set) | ({32{sel_status}} & status_word) |
                           ({32{sel_cmd}} & rd_cmd) | ({32{sel_speed}} & rd_speed) |
                           ({32{sel_id}} & rd_id);

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            op_src_q    <= twsw_pkg::OP_SRC_RST;
            spd_src_q   <= twsw_pkg::SPD_SRC_RST;
            settings_q  <= 2'h0;
            net_cmd_q   <= 8'h00;
            net_speed_q <= 16'h0000;
        end else begin
            if (wr_op) op_src_q <= i_reg_wdata[0];
            if (wr_spd && spd_ok) spd_src_q <= i_reg_wdata[1:0];
            if (wr_set) settings_q <= i_reg_wdata[1:0];
            if (wr_cmd) net_cmd_q <= i_reg_wdata[7:0];
            if (wr_speed) net_speed_q <= i_reg_wdata[15:0];
        end
    end

    // Read data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= i_reg_rd ? rdata_d : 32'h00000000;
        end
    end

    // Two-way request synchroniser; only the second stage is looked at
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            req_s1_q <= src.two_way_req;
            req_s2_q <= req_s1_q;
        end
    end

    wire mode_dancer  = (i_ctrl_mode == twsw_pkg::TWSW_SPD_DANCER);
    wire mode_tension = (i_ctrl_mode == twsw_pkg::TWSW_SPD_TENSION);
    wire speed_mode   = mode_dancer || mode_tension;
    // Speed modes wait for a stopped ramp; torque modes switch at once
    wire change_ok  = !speed_mode || at_zero;
    wire change_req = (req_s2_q != swap_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            twsw_pkg::TWSW_ST_NORMAL: begin
                if (change_req && !change_ok) state_d = twsw_pkg::TWSW_ST_HOLD;
                else if (change_req) state_d = twsw_pkg::TWSW_ST_SWAP;
            end
            twsw_pkg::TWSW_ST_HOLD: begin
                if (!change_req) state_d = twsw_pkg::TWSW_ST_NORMAL;
                else if (change_ok) state_d = twsw_pkg::TWSW_ST_SWAP;
            end
            twsw_pkg::TWSW_ST_SWAP: state_d = twsw_pkg::TWSW_ST_NORMAL;
            default:                state_d = twsw_pkg::TWSW_ST_NORMAL;
        endcase
    end
    wire take = change_req && change_ok;

    // Changeover progress, readable in the status word
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            state_q <= twsw_pkg::TWSW_ST_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // Accepted two-way state; starts off so the configured behaviour applies
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            swap_q <= 1'b0;
        end else if (take) begin
            swap_q <= req_s2_q;
        end
    end

    // Effective settings derived live from the stored ones, so nothing is rewritten
    wire inv_speed = swap_q && speed_mode;
    wire pid_d     = settings_q[twsw_pkg::SET_PID_BIT] ^ inv_speed;
    wire wind_d    = settings_q[twsw_pkg::SET_WIND_BIT] ^ swap_q;
    wire fwd_d     = inv_speed ? src.rev_start : src.fwd_start;
    wire rev_d     = inv_speed ? src.fwd_start : src.rev_start;
    // PID output is passed through untouched so the sense flip adds no step
    wire [15:0] speed_d = src.net_speed_ok ? net_speed_q : 16'h0000;

    // Settings view: stored values flipped by the accepted two-way state, PID sense in speed modes only
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            pid_sense_q <= 1'b0;
            wind_sel_q  <= 1'b0;
        end else begin
            pid_sense_q <= pid_d;
            wind_sel_q  <= wind_d;
        end
    end

    // Rotation actually commanded to the motor
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            run_fwd_q <= 1'b0;
            run_rev_q <= 1'b0;
        end else begin
            run_fwd_q <= fwd_d;
            run_rev_q <= rev_d;
        end
    end

    // Panel keeps showing the start the operator gave, whatever the swap
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            panel_fwd_q <= 1'b0;
            panel_rev_q <= 1'b0;
        end else begin
            panel_fwd_q <= src.fwd_start;
            panel_rev_q <= src.rev_start;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            pid_mv_q <= 16'h0000;
        end else begin
            pid_mv_q <= i_pid_mv;
        end
    end

    // Line speed from the register only while the speed source allows it
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            line_speed_q <= 16'h0000;
        end else begin
            line_speed_q <= speed_d;
        end
    end

    // Commands picked by the source selectors
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            tune_q <= 1'b0;
        end else begin
            tune_q <= src.tune_cmd;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            step_q <= 3'h0;
            rex_q  <= 1'b0;
        end else begin
            step_q <= src.step_speed;
            rex_q  <= src.rex_sel;
        end
    end

    assign o_reg_rdata      = rdata_q;
    assign o_pid_sense      = pid_sense_q;
    assign o_wind_sel       = wind_sel_q;
    assign o_run_fwd        = run_fwd_q;
    assign o_run_rev        = run_rev_q;
    assign o_panel_fwd      = panel_fwd_q;
    assign o_panel_rev      = panel_rev_q;
    assign o_swapped        = swap_q;
    assign o_pid_mv         = pid_mv_q;
    assign o_line_speed_cmd = line_speed_q;
    assign o_tune_cmd       = tune_q;
    assign o_step_speed     = step_q;
    assign o_rex_sel        = rex_q;
endmodule

/* File: testbench/twsw_monitor.sv */
// Port-level concurrent checks for the two-way winding switch
`timescale 1ns/10ps
module twsw_monitor (
    input wire logic        i_core_clk,
    input wire logic        i_rstn,
    input wire logic [3:0]  i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic [1:0]  i_ctrl_mode,
    input wire logic        i_ramp_busy,
    input wire logic [15:0] i_pid_mv,
    input wire logic        o_pid_sense,
    input wire logic        o_wind_sel,
    input wire logic        o_run_fwd,
    input wire logic        o_run_rev,
    input wire logic        o_panel_fwd,
    input wire logic        o_panel_rev,
    input wire logic        o_swapped,
    input wire logic [15:0] o_pid_mv
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    wire spd_mode = !i_ctrl_mode[1];
    a_reset_clear: assert property ($rose(i_rstn) |-> !o_swapped && !o_pid_sense
        && !o_wind_sel && !o_run_fwd && !o_run_rev) else $error("outputs not clear after reset");
    a_wind_swap: assert property ($changed(o_swapped) && $stable(i_ctrl_mode)
        && !$past(i_reg_wr) |=> o_wind_sel != $past(o_wind_sel)) else $error("wind not inverted");
    a_pid_speed_swap: assert property (spd_mode && $changed(o_swapped)
        && $stable(i_ctrl_mode) && !$past(i_reg_wr) |=> o_pid_sense != $past(o_pid_sense))
        else $error("pid sense not inverted");
    a_pid_torque_keep: assert property (!spd_mode && $stable(i_ctrl_mode)
        && !$past(i_reg_wr) |=> $stable(o_pid_sense)) else $error("pid sense moved in torque");
    a_dir_speed_swap: assert property ((spd_mode && $stable(o_swapped))[*3]
        |-> o_run_fwd == (o_swapped ? o_panel_rev : o_panel_fwd)) else $error("run dir wrong");
    a_dir_torque_keep: assert property ((!spd_mode)[*2]
        |-> o_run_fwd == o_panel_fwd && o_run_rev == o_panel_rev) else $error("torque dir moved");
    a_busy_hold_swap: assert property ((i_ramp_busy && spd_mode)[*3]
        |=> $stable(o_swapped)) else $error("swap while ramp busy");
    a_read_idle_zero: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0000_0000)
        else $error("read data not zero when idle");
    a_id_read_value: assert property (i_reg_rd && i_reg_addr == twsw_pkg::ADDR_ID
        |=> o_reg_rdata == {16'h0000, twsw_pkg::BLOCK_ID}) else $error("id read wrong");
    a_pid_mv_pass: assert property ($past(i_rstn) |-> o_pid_mv == $past(i_pid_mv))
        else $error("pid output stepped");
    c_speed_swap: cover property (spd_mode && $rose(o_swapped));
    c_torque_swap: cover property (!spd_mode && $rose(o_swapped));
    c_id_read: cover property (i_reg_rd && i_reg_addr == twsw_pkg::ADDR_ID);
endmodule

bind twsw_top twsw_monitor i_twsw_monitor (.i_core_clk, .i_rstn, .i_reg_addr, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_ctrl_mode, .i_ramp_busy, .i_pid_mv, .o_pid_sense, .o_wind_sel,
    .o_run_fwd, .o_run_rev, .o_panel_fwd, .o_panel_rev, .o_swapped, .o_pid_mv);

/* File: testbench/twsw_term_model.sv */
// Terminal strip and line speed ramp source facing the switch block
`timescale 1ns/10ps
module twsw_term_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_level,
    input  wire logic        i_force_zero,
    input  wire logic [15:0] i_speed,
    output logic      [7:0]  o_func_sel,
    output logic             o_func_in,
    output logic      [15:0] o_ramp_speed
);
    assign o_func_sel = twsw_pkg::FUNC_TWO_WAY;
    // Starting line speed pulls the ramp to zero when the analog input cannot
    assign o_ramp_speed = i_force_zero ? twsw_pkg::SPEED_ZERO : i_speed;
    always_ff @(posedge i_core_clk) begin
        o_func_in <= i_level;
    end
endmodule

/* File: testbench/twsw_top_tb.sv */
// Self-checking bench for the two-way winding switch
`timescale 1ns/10ps
module twsw_top_tb;
    logic        clk, rstn, wr, rd, tw_lvl, zero_f, busy, tune, fwd, rev, fifteen_speed_select, fin;
    logic        pid_s, wind, run_f, run_r, pan_f, pan_r, swp, tune_o, rex_o;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata;
    logic [1:0]  mode;
    logic [2:0]  step, step_o;
    logic [7:0]  fsel;
    logic [15:0] spd, ramp, mv, mv_o, ls;
    int          fails, cmp_count, cycles;
    twsw_term_model i_twsw_term_model (.i_core_clk(clk), .i_level(tw_lvl), .i_force_zero(zero_f),
        .i_speed(spd), .o_func_sel(fsel), .o_func_in(fin), .o_ramp_speed(ramp));
    twsw_top i_twsw_top (.i_core_clk(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_ctrl_mode(mode),
        .i_term_func_sel(fsel), .i_term_func_in(fin), .i_term_tune(tune),
        .i_forward_start_input(fwd), .i_reverse_start_input(rev), .i_term_step(step),
        .i_term_rex(fifteen_speed_select), .i_net_line_speed(16'h0000), .i_ramp_speed(ramp), .i_ramp_busy(busy),
        .i_pid_mv(mv), .o_pid_sense(pid_s), .o_wind_sel(wind), .o_run_fwd(run_f),
        .o_run_rev(run_r), .o_panel_fwd(pan_f), .o_panel_rev(pan_r), .o_swapped(swp),
        .o_pid_mv(mv_o), .o_line_speed_cmd(ls), .o_tune_cmd(tune_o), .o_step_speed(step_o),
        .o_rex_sel(rex_o));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task conclude;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            conclude;
        end
    end
    task chk_b(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [3:0] a, input logic [31:0] e, input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk_w(n, e, rdata);
    endtask
    // Bounded wait for the accepted two-way state, then let the derived outputs land
    task wait_sw(input logic e);
        for (int i = 0; i < 20 && swp !== e; i++) @(posedge clk);
        chk_b("swapped", e, swp);
        repeat (3) @(posedge clk);
    endtask
    task t_regs;
        rd_chk(twsw_pkg::ADDR_OP_SRC, 32'h0, "op_src reset");
        rd_chk(twsw_pkg::ADDR_SPD_SRC, 32'h0, "spd_src reset");
        reg_wr(twsw_pkg::ADDR_SPD_SRC, 32'h2);
        reg_wr(twsw_pkg::ADDR_SPD_SRC, 32'h3);
        rd_chk(twsw_pkg::ADDR_SPD_SRC, 32'h2, "spd_src refuse");
        reg_wr(4'hF, 32'hFFFF_FFFF);
        rd_chk(4'hF, 32'h0, "unmapped");
        rd_chk(twsw_pkg::ADDR_ID, {16'h0000, twsw_pkg::BLOCK_ID}, "id");
    endtask
    task t_speed_swap;
        reg_wr(twsw_pkg::ADDR_OP_SRC, 32'h1);
        mode <= twsw_pkg::TWSW_SPD_DANCER;
        fwd <= 1'b1;
        mv <= 16'h0ABC;
        busy <= 1'b1;
        zero_f <= 1'b0;
        tw_lvl <= 1'b1;
        repeat (10) @(posedge clk);
        chk_b("held busy", 1'b0, swp);
        busy <= 1'b0;
        zero_f <= 1'b1;
        wait_sw(1'b1);
        chk_b("pid sense", 1'b1, pid_s);
        chk_b("wind", 1'b1, wind);
        chk_b("run rev", 1'b1, run_r);
        chk_b("run fwd", 1'b0, run_f);
        chk_b("panel fwd", 1'b1, pan_f);
        chk_w("pid mv", 32'h0ABC, {16'h0000, mv_o});
        tw_lvl <= 1'b0;
        wait_sw(1'b0);
        chk_b("run fwd back", 1'b1, run_f);
    endtask
    task t_torque_swap;
        for (int m = 2; m < 4; m++) begin
            mode <= 2'(m);
            busy <= 1'b1;
            zero_f <= 1'b0;
            tw_lvl <= 1'b1;
            wait_sw(1'b1);
            chk_b("torque pid", 1'b0, pid_s);
            chk_b("torque wind", 1'b1, wind);
            chk_b("torque run", 1'b1, run_f);
            tw_lvl <= 1'b0;
            wait_sw(1'b0);
        end
    endtask
    task t_sources;
        mode <= twsw_pkg::TWSW_SPD_TENSION;
        busy <= 1'b0;
        zero_f <= 1'b1;
        tune <= 1'b1;
        reg_wr(twsw_pkg::ADDR_OP_SRC, 32'h0);
        tw_lvl <= 1'b1;
        repeat (10) @(posedge clk);
        chk_b("term ignored", 1'b0, swp);
        chk_b("term tune off", 1'b0, tune_o);
        reg_wr(twsw_pkg::ADDR_NET_CMD, 32'h53);
        wait_sw(1'b1);
        chk_b("net tune", 1'b1, tune_o);
        tw_lvl <= 1'b0;
        step <= 3'b010;
        fifteen_speed_select <= 1'b1;
        reg_wr(twsw_pkg::ADDR_OP_SRC, 32'h1);
        wait_sw(1'b0);
        chk_b("term tune", 1'b1, tune_o);
        for (int s = 0; s < 3; s++) begin
            reg_wr(twsw_pkg::ADDR_SPD_SRC, 32'(s));
            repeat (3) @(posedge clk);
            chk_w("step", (s == 1) ? 32'h2 : 32'h5, {29'h0, step_o});
            chk_b("rex", s == 1, rex_o);
        end
        tune <= 1'b0;
    endtask
    task t_line_speed;
        reg_wr(twsw_pkg::ADDR_NET_SPEED, 32'h1234);
        for (int o = 0; o < 2; o++) begin
            reg_wr(twsw_pkg::ADDR_OP_SRC, 32'(o));
            for (int s = 0; s < 3; s++) begin
                reg_wr(twsw_pkg::ADDR_SPD_SRC, 32'(s));
                repeat (3) @(posedge clk);
                chk_w("line speed", (s == 1) ? 32'h0 : 32'h1234, {16'h0000, ls});
            end
        end
    endtask
    task t_settings;
        reg_wr(twsw_pkg::ADDR_SETTINGS, 32'h3);
        rd_chk(twsw_pkg::ADDR_SETTINGS, 32'h3, "settings");
        chk_b("cfg pid", 1'b1, pid_s);
        chk_b("cfg wind", 1'b1, wind);
        tw_lvl <= 1'b1;
        wait_sw(1'b1);
        chk_b("cfg pid swap", 1'b0, pid_s);
        chk_b("cfg wind swap", 1'b0, wind);
        rd_chk(twsw_pkg::ADDR_STATUS, 32'h11, "status");
        tw_lvl <= 1'b0;
        wait_sw(1'b0);
    endtask
    initial begin
        {rstn, wr, rd, tw_lvl, busy, tune, fwd, rev, fifteen_speed_select} = 9'h000;
        zero_f = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        mode = 2'h0;
        step = 3'h0;
        spd = 16'h0100;
        mv = 16'h0000;
        fails = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_speed_swap;
        t_torque_swap;
        t_sources;
        t_line_speed;
        t_settings;
        conclude;
    end
endmodule
